//--- hdl/serial_port_four_mode.v
// Four-mode serial port: register access, shift mode and async framing.
//
// Behaviour
// - In modes 1 to 3 transmit and receive paths are independent and may run together.
// - A received byte stays readable while the next one arrives.
// - Buffer writes load the transmitter; buffer reads return receive holding.
// - Mode 0 shifts 8 bits LSB first on rxd, clock on txd at osc/12.
// - Mode 1 frame: start 0, 8 data bits LSB first, stop 1.
// - Mode 1 stores the received stop bit in the rx ninth bit flag.
// - Modes 2 and 3 frame: start, 8 data bits, ninth bit, stop.
// - Modes 2 and 3 send the software tx ninth bit as bit nine.
// - Modes 2 and 3 store received ninth bit, ignoring the stop bit.
// - Mode 2 bit rate is osc/64 or osc/32.
// - Modes 1 and 3 use the variable bit rate; mode 3 equals mode 2.
// - Any buffer write starts a transmission in every mode.
// - Mode 0 reception starts when rx done is clear and rx enabled.
// - Modes 1 to 3 start reception on a start bit when rx enabled.
// - Tx done and rx done flags set at frame end, pollable.
// - Modes 2 and 3 with multiproc enable flag only ninth bit one.
// - Mode 1 with multiproc enable flags only with valid stop bit.
// - Multiproc enable has no effect in mode 0.
// - Mode bits: 00 shift, 01 8-bit variable, 10 9-bit fixed, 11 variable.
// - Receive enable changes only by software and gates the start of each reception; only mode 0 aborts a reception on disable.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "serial_port_consts.vh"
module serial_port_four_mode (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Register port
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdata,
	// Variable rate tick, sixteen per bit
	input wire baudTick,
	// Serial pins
	input wire rxdIn,
	output reg rxdOut,
	output reg rxdOe,
	output reg txd,
	// Event flags
	output reg txDoneFlag,
	output reg rxDoneFlag
);
	// ********************
	// Address decode
	// ********************
	function hit;
		input [7:0] addr;
		input [7:0] loc;
		begin
			hit = (addr == loc);
		end
	endfunction

	// ********************
	// Reset release and pin synchronisers
	// ********************
	reg [1:0] rstSync_q;
	reg rxdMeta_q;
	reg rxdSync_q;
	// The rate clock comes from another domain: two stages, then an edge.
	reg [2:0] baudSync_q;
	wire rstn = rstSync_q[1];
	wire baudEdge = baudSync_q[1] && !baudSync_q[2];

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'b00;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rxdMeta_q <= 1'b1;
			rxdSync_q <= 1'b1;
			baudSync_q <= 3'h0;
		end else begin
			rxdMeta_q <= rxdIn;
			rxdSync_q <= rxdMeta_q;
			baudSync_q <= {baudSync_q[1:0], baudTick};
		end
	end

	// ********************
	// Control state
	// ********************
	reg [1:0] modeSel_q;
	reg multiprocEnable_q;
	reg rxEnable_q;
	reg txNinth_q;
	reg rxNinth_q;
	reg rxHoldFull_q;
	reg txDone_q;
	reg [7:0] rxHold_q;
	reg rateFast_q;
	reg overrun_q;

	wire ctrlWr = regWrite && hit(regAddr, `ADDR_CTRL);
	wire bufWr = regWrite && hit(regAddr, `ADDR_BUF);
	wire rateWr = regWrite && hit(regAddr, `ADDR_RATE);
	wire statWr = regWrite && hit(regAddr, `ADDR_STAT);
	wire modeShift = (modeSel_q == `MODE_SHIFT);
	wire modeNine = modeSel_q[1];

	// ********************
	// Bit-rate ticks
	// ********************
	// Mode 2 divides the oscillator by 2 or 4 into sixteen ticks per bit,
	// so one bit lasts 32 or 64 oscillator periods.
	reg [1:0] fixCnt_q;
	reg fixTick_q;
	wire [1:0] fixLast = rateFast_q ? `FIX_FAST_LAST : `FIX_SLOW_LAST;

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fixCnt_q <= 2'h0;
			fixTick_q <= 1'b0;
		end else begin
			fixTick_q <= (fixCnt_q == fixLast);
			fixCnt_q <= (fixCnt_q == fixLast) ? 2'h0 : fixCnt_q + 2'h1;
		end
	end

	// Modes 1 and 3 run from the outside rate generator.
	wire osTick = (modeSel_q == `MODE_UART9F) ? fixTick_q : baudEdge;

	// ********************
	// Asynchronous transmitter and receiver
	// ********************
	wire txLine;
	wire txBusy;
	wire txDoneP;
	wire [7:0] rxData;
	wire rxBit9;
	wire rxStopOk;
	wire rxBusy;
	wire rxDoneP;

	// Separate engines let a frame go out while another arrives.
	serial_tx u_tx (
		.clk(ref_clk),
		.rstn(rstn),
		.tick(osTick),
		.start(bufWr && !modeShift),
		.data(regWdata),
		.ninth(txNinth_q),
		.nine(modeNine),
		.line(txLine),
		.busy(txBusy),
		.done(txDoneP)
	);

	serial_rx u_rx (
		.clk(ref_clk),
		.rstn(rstn),
		.tick(osTick),
		.rxIn(rxdSync_q),
		.enable(rxEnable_q && !modeShift),
		.nine(modeNine),
		.data(rxData),
		.bit9(rxBit9),
		.stopOk(rxStopOk),
		.busy(rxBusy),
		.done(rxDoneP)
	);

	// Frame filter: in mode 1 the stop bit must be valid, in modes 2 and 3
	// the ninth bit must be one, whenever multiprocessor filtering is on.
	wire frameWanted = !multiprocEnable_q ||
		(modeNine ? rxBit9 : rxStopOk);
	// The holding register is never overwritten while rx done is set, so the
	// newer byte is the one that is lost.
	wire frameAccept = rxDoneP && frameWanted && !rxHoldFull_q;
	wire frameLost = rxDoneP && frameWanted && rxHoldFull_q;

	// ********************
	// Shift register mode engine
	// ********************
	reg shBusy_q;
	reg shTx_q;
	reg [3:0] shCnt_q;
	reg [2:0] shBit_q;
	reg [7:0] shData_q;
	reg shDone_q;
	// Multiprocessor enable plays no part in this path.
	wire shRxStart = modeShift && rxEnable_q && !rxHoldFull_q &&
		!shBusy_q && !bufWr;

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shBusy_q <= 1'b0;
			shTx_q <= 1'b0;
			shCnt_q <= 4'h0;
			shBit_q <= 3'h0;
			shData_q <= 8'h00;
			shDone_q <= 1'b0;
		end else begin
			shDone_q <= 1'b0;
			if (bufWr && modeShift) begin
				shBusy_q <= 1'b1;
				shTx_q <= 1'b1;
				shCnt_q <= 4'h0;
				shBit_q <= 3'h0;
				shData_q <= regWdata;
			end else if (shRxStart) begin
				shBusy_q <= 1'b1;
				shTx_q <= 1'b0;
				shCnt_q <= 4'h0;
				shBit_q <= 3'h0;
			end else if (shBusy_q) begin
				if (!modeShift || (!shTx_q && !rxEnable_q)) begin
					// Leaving the mode or disabling reception aborts.
					shBusy_q <= 1'b0;
				end else begin
					shCnt_q <= (shCnt_q == `SHIFT_LAST) ?
						4'h0 : shCnt_q + 4'h1;
					if (!shTx_q && shCnt_q == `SHIFT_HALF) begin
						shData_q <= {rxdSync_q, shData_q[7:1]};
					end
					if (shCnt_q == `SHIFT_LAST) begin
						if (shTx_q) begin
							shData_q <= {1'b1, shData_q[7:1]};
						end
						if (shBit_q == 3'h7) begin
							shBusy_q <= 1'b0;
							shDone_q <= 1'b1;
						end else begin
							shBit_q <= shBit_q + 3'h1;
						end
					end
				end
			end
		end
	end

	// ********************
	// Completion events
	// ********************
	wire txEvt = txDoneP || (shDone_q && shTx_q);
	wire rxEvtShift = shDone_q && !shTx_q;
	wire rxEvt = frameAccept || rxEvtShift;

	// ********************
	// Register writes and hardware updates
	// ********************
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			modeSel_q <= 2'b00;
			multiprocEnable_q <= 1'b0;
			rxEnable_q <= 1'b0;
			txNinth_q <= 1'b0;
			rxNinth_q <= 1'b0;
			rxHoldFull_q <= 1'b0;
			txDone_q <= 1'b0;
			rxHold_q <= 8'h00;
			rateFast_q <= `RATE_RESET;
			overrun_q <= 1'b0;
		end else begin
			if (ctrlWr) begin
				modeSel_q <= {regWdata[`BIT_MODE_HI],
					regWdata[`BIT_MODE_LO]};
				multiprocEnable_q <= regWdata[`BIT_MPE];
				rxEnable_q <= regWdata[`BIT_RXEN];
				txNinth_q <= regWdata[`BIT_TX9];
			end
			if (rateWr) begin
				rateFast_q <= regWdata[`BIT_RATE_FAST];
			end
			// Hardware loads win over a software write in the same cycle.
			if (frameAccept) begin
				rxHold_q <= rxData;
				rxNinth_q <= rxBit9;
			end else if (rxEvtShift) begin
				rxHold_q <= shData_q;
			end else if (ctrlWr) begin
				rxNinth_q <= regWdata[`BIT_RX9];
			end
			// Flags are set by hardware or by a software write, and cleared only by software.
			if (txEvt) begin
				txDone_q <= 1'b1;
			end else if (ctrlWr) begin
				txDone_q <= regWdata[`BIT_TXDONE];
			end
			if (rxEvt) begin
				rxHoldFull_q <= 1'b1;
			end else if (ctrlWr) begin
				rxHoldFull_q <= regWdata[`BIT_RXDONE];
			end
			if (frameLost) begin
				overrun_q <= 1'b1;
			end else if (statWr) begin
				overrun_q <= regWdata[`BIT_ST_OVERRUN];
			end
		end
	end

	// ********************
	// Register reads
	// ********************
	reg [7:0] readMux;

	always @* begin
		readMux = 8'h00;
		if (hit(regAddr, `ADDR_CTRL)) begin
			readMux[`BIT_MODE_HI] = modeSel_q[1];
			readMux[`BIT_MODE_LO] = modeSel_q[0];
			readMux[`BIT_MPE] = multiprocEnable_q;
			readMux[`BIT_RXEN] = rxEnable_q;
			readMux[`BIT_TX9] = txNinth_q;
			readMux[`BIT_RX9] = rxNinth_q;
			readMux[`BIT_TXDONE] = txDone_q;
			readMux[`BIT_RXDONE] = rxHoldFull_q;
		end else if (hit(regAddr, `ADDR_BUF)) begin
			readMux = rxHold_q;
		end else if (hit(regAddr, `ADDR_RATE)) begin
			readMux[`BIT_RATE_FAST] = rateFast_q;
		end else if (hit(regAddr, `ADDR_STAT)) begin
			readMux[`BIT_ST_OVERRUN] = overrun_q;
			readMux[`BIT_ST_RXBUSY] = rxBusy || (shBusy_q && !shTx_q);
			readMux[`BIT_ST_TXBUSY] = txBusy || (shBusy_q && shTx_q);
		end
	end

	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 8'h00;
		end else begin
			// Data stand only in the cycle after the read strobe.
			regRdata <= regRead ? readMux : 8'h00;
		end
	end

	// ********************
	// Pin drivers
	// ********************
	// The shift clock is low for the first half of each twelve-cycle bit
	// and rises mid-bit, where the receive sample is taken.
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			txd <= 1'b1;
			rxdOut <= 1'b1;
			rxdOe <= 1'b0;
			txDoneFlag <= 1'b0;
			rxDoneFlag <= 1'b0;
		end else begin
			if (modeShift) begin
				txd <= shBusy_q ? (shCnt_q >= `SHIFT_HALF) : 1'b1;
			end else begin
				txd <= txLine;
			end
			rxdOe <= shBusy_q && shTx_q;
			rxdOut <= (shBusy_q && shTx_q) ? shData_q[0] : 1'b1;
			txDoneFlag <= txDone_q;
			rxDoneFlag <= rxHoldFull_q;
		end
	end
endmodule // serial_port_four_mode

//--- hdl/serial_port_consts.vh
// Register map, field positions, reset values and timing counts.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
// ********************
// Register addresses
// ********************
`define ADDR_CTRL 8'h98
`define ADDR_BUF 8'h99
`define ADDR_RATE 8'h9a
`define ADDR_STAT 8'h9b
// ********************
// Reset values
// ********************
`define CTRL_RESET 8'h00
`define RATE_RESET 1'b0
// ********************
// Control register fields
// ********************
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_MPE 5
`define BIT_RXEN 4
`define BIT_TX9 3
`define BIT_RX9 2
`define BIT_TXDONE 1
`define BIT_RXDONE 0
// ********************
// Rate and status fields
// ********************
`define BIT_RATE_FAST 0
`define BIT_ST_OVERRUN 2
`define BIT_ST_RXBUSY 1
`define BIT_ST_TXBUSY 0
// ********************
// Modes
// ********************
`define MODE_SHIFT 2'b00
`define MODE_UART8 2'b01
`define MODE_UART9F 2'b10
`define MODE_UART9V 2'b11
// ********************
// Timing counts
// ********************
`define SHIFT_LAST 4'hb
`define SHIFT_HALF 4'h6
`define OS_LAST 4'hf
`define OS_MID 4'h8
`define FIX_SLOW_LAST 2'h3
`define FIX_FAST_LAST 2'h1
`endif

//--- hdl/serial_tx.v
// Asynchronous frame transmitter for the 8-bit and 9-bit modes.
`timescale 1ns/100ps
`include "serial_port_consts.vh"
module serial_tx (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Sixteen-times bit-rate tick
	input wire tick,
	// Load request
	input wire start,
	input wire [7:0] data,
	input wire ninth,
	input wire nine,
	// Line and status
	output reg line,
	output reg busy,
	output reg done
);
	reg [10:0] sh_q;
	reg [3:0] bitCnt_q;
	reg [3:0] osCnt_q;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sh_q <= 11'h7ff;
			bitCnt_q <= 4'h0;
			osCnt_q <= 4'h0;
			line <= 1'b1;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// A new load restarts any frame in flight.
				sh_q <= {1'b1, (nine ? ninth : 1'b1), data, 1'b0};
				bitCnt_q <= nine ? 4'hb : 4'ha;
				osCnt_q <= 4'h0;
				line <= 1'b0;
				busy <= 1'b1;
			end else if (busy && tick) begin
				if (osCnt_q == `OS_LAST) begin
					osCnt_q <= 4'h0;
					if (bitCnt_q == 4'h1) begin
						busy <= 1'b0;
						done <= 1'b1;
						line <= 1'b1;
					end else begin
						sh_q <= {1'b1, sh_q[10:1]};
						line <= sh_q[1];
						bitCnt_q <= bitCnt_q - 4'h1;
					end
				end else begin
					osCnt_q <= osCnt_q + 4'h1;
				end
			end
		end
	end
endmodule // serial_tx

//--- hdl/serial_rx.v
// Asynchronous frame receiver for the 8-bit and 9-bit modes.
`timescale 1ns/100ps
`include "serial_port_consts.vh"
module serial_rx (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Sixteen-times bit-rate tick
	input wire tick,
	// Synchronised line and control
	input wire rxIn,
	input wire enable,
	input wire nine,
	// Completed frame
	output reg [7:0] data,
	output reg bit9,
	output reg stopOk,
	output reg busy,
	output reg done
);
	reg [8:0] sh_q;
	reg [3:0] bitCnt_q;
	reg [3:0] osCnt_q;
	reg prev_q;
	wire [3:0] lastBit;

	assign lastBit = nine ? 4'ha : 4'h9;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sh_q <= 9'h000;
			bitCnt_q <= 4'h0;
			osCnt_q <= 4'h0;
			prev_q <= 1'b1;
			data <= 8'h00;
			bit9 <= 1'b0;
			stopOk <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (tick) begin
				prev_q <= rxIn;
			end
			if (!busy) begin
				if (tick && enable && prev_q && !rxIn) begin
					busy <= 1'b1;
					bitCnt_q <= 4'h0;
					osCnt_q <= 4'h1;
				end
			end else if (tick) begin
				osCnt_q <= osCnt_q + 4'h1;
				if (osCnt_q == `OS_MID) begin
					if (bitCnt_q == 4'h0 && rxIn) begin
						// A glitch, not a start bit.
						busy <= 1'b0;
					end else if (bitCnt_q == lastBit) begin
						busy <= 1'b0;
						done <= 1'b1;
						stopOk <= rxIn;
						data <= nine ? sh_q[7:0] : sh_q[8:1];
						bit9 <= nine ? sh_q[8] : rxIn;
					end else begin
						if (bitCnt_q != 4'h0) begin
							sh_q <= {rxIn, sh_q[8:1]};
						end
						bitCnt_q <= bitCnt_q + 4'h1;
					end
				end
			end
		end
	end
endmodule // serial_rx

//--- dv/serial_port_four_mode_asserts.sv
// Port-level checker for the four-mode serial port.
`timescale 1ns/100ps
`include "serial_port_consts.vh"
module serial_port_four_mode_asserts (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Register port
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regRdata,
	// Line and flags
	input wire baudTick,
	input wire rxdIn,
	input wire rxdOut,
	input wire rxdOe,
	input wire txd,
	input wire txDoneFlag,
	input wire rxDoneFlag
);
	// A software write reaches the flag outputs two edges later.
	wire ctrlWr = regWrite && regAddr == `ADDR_CTRL;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// ********************
	// Assertions
	// ********************
	AST_RD_IDLE: assert property (
		!$past(regRead) |-> regRdata == 8'h00)
		else $error("read data outside its slot");
	AST_FLAG_POLL: assert property (
		regRead && regAddr == `ADDR_CTRL |=>
		regRdata[1:0] == {txDoneFlag, rxDoneFlag})
		else $error("polled flags differ from flag outputs");
	AST_TX_START: assert property (
		regWrite && regAddr == `ADDR_BUF |-> ##2 !txd)
		else $error("buffer write did not start a frame");
	AST_SHIFT_LOW: assert property (
		rxdOe && $fell(txd) |=> !txd [*5] ##1 txd)
		else $error("shift clock low phase not six cycles");
	AST_SHIFT_HIGH: assert property (
		rxdOe && $rose(txd) |=> txd [*5])
		else $error("shift clock high phase too short");
	AST_SHIFT_HOLD: assert property (
		rxdOe && $fell(txd) |=> $stable(rxdOut) [*8])
		else $error("shift data changed inside its bit");
	AST_TXDONE_HOLD: assert property (
		!ctrlWr ##1 txDoneFlag |=> txDoneFlag)
		else $error("tx done dropped without software");
	AST_RXDONE_HOLD: assert property (
		!ctrlWr ##1 rxDoneFlag |=> rxDoneFlag)
		else $error("rx done dropped without software");
endmodule // serial_port_four_mode_asserts
bind serial_port_four_mode serial_port_four_mode_asserts chk_u (
	.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
	.regRdata(regRdata), .baudTick(baudTick), .rxdIn(rxdIn),
	.rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd),
	.txDoneFlag(txDoneFlag), .rxDoneFlag(rxDoneFlag));

//--- dv/serial_peer.sv
// Line-side model of a remote serial device.
`timescale 1ns/100ps
module serial_peer (
	// Clock
	input wire clk,
	// Frame setup
	input wire shift,
	input wire nine,
	input wire [7:0] bitLen,
	// Serial pins
	input wire txd,
	input wire rxdOut,
	input wire rxdOe,
	output reg line,
	// Last frame seen: start, stop, ninth and data bits
	output reg [10:0] cap
);
	reg [7:0] outSr;
	reg txdPrev;
	reg rose;
	integer i;
	integer j;
	initial begin
		line = 1'b1;
		cap = 11'h000;
		outSr = 8'hff;
		txdPrev = 1'b1;
		rose = 1'b0;
	end
	// ********************
	// Frames
	// ********************
	task sendAsync(input [8:0] d, input stp);
		begin
			line <= 1'b0;
			repeat (bitLen) @(posedge clk);
			for (i = 0; i < (nine ? 9 : 8); i = i + 1) begin
				line <= d[i];
				repeat (bitLen) @(posedge clk);
			end
			line <= stp;
			repeat (bitLen) @(posedge clk);
			line <= 1'b1;
			@(posedge clk);
		end
	endtask
	// Sampling at mid-bit tolerates a few cycles of start offset.
	always @(negedge txd) begin
		if (!shift) begin
			cap <= 11'h000;
			repeat (bitLen / 2) @(posedge clk);
			cap[10] <= txd;
			for (j = 0; j < (nine ? 9 : 8); j = j + 1) begin
				repeat (bitLen) @(posedge clk);
				cap[j] <= txd;
			end
			repeat (bitLen) @(posedge clk);
			cap[9] <= txd;
		end
	end
	// Shift data changes only on a falling shift clock after a rise.
	always @(posedge clk) begin
		txdPrev <= txd;
		if (shift && txd && !txdPrev) begin
			rose <= 1'b1;
			if (rxdOe)
				cap[7:0] <= {rxdOut, cap[7:1]};
		end
		if (shift && !txd && txdPrev && rose && !rxdOe) begin
			line <= outSr[0];
			outSr <= {1'b1, outSr[7:1]};
		end
	end
	always @(negedge shift)
		line <= 1'b1;
	task armShift(input [7:0] d);
		begin
			line <= d[0];
			outSr <= {1'b1, d[7:1]};
			rose <= 1'b0;
		end
	endtask
endmodule // serial_peer

//--- dv/serial_port_four_mode_tb.sv
// Self-checking bench for the four-mode serial port.
`timescale 1ns/100ps
`include "serial_port_consts.vh"
module serial_port_four_mode_tb;
	reg ref_clk, resetn, regWrite, regRead, baudTick, shift, nine;
	reg [7:0] regAddr, regWdata, bitLen, v, c;
	reg [2:0] tickCnt;
	reg [31:0] r;
	wire [7:0] regRdata;
	wire [10:0] cap;
	wire rxdOut, rxdOe, txd, txDoneFlag, rxDoneFlag, peerLine;
	// The pin is driven by the peer whenever the port releases it.
	wire rxdIn = rxdOe ? rxdOut : peerLine;
	integer n_fail, compares, cycles, k, seed;
	// Mode, multiproc, rx enable, ninth, stop, fast, flag expected.
	reg [7:0] cases [0:7] = '{8'h55, 8'h9d, 8'h97, 8'hdd, 8'h70,
		8'hf4, 8'hfd, 8'h44};
	serial_port_four_mode dut_u (
		.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .baudTick(baudTick), .rxdIn(rxdIn),
		.rxdOut(rxdOut), .rxdOe(rxdOe), .txd(txd),
		.txDoneFlag(txDoneFlag), .rxDoneFlag(rxDoneFlag));
	serial_peer peer_u (.clk(ref_clk), .shift(shift), .nine(nine),
		.bitLen(bitLen), .txd(txd), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.line(peerLine), .cap(cap));
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		tickCnt <= tickCnt + 3'h1;
		baudTick <= tickCnt[2];
	end
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			n_fail = n_fail + 1;
			results;
		end
	end
	// ********************
	// Tasks
	// ********************
	function [7:0] bitClocks(input [1:0] m, input f);
		bitClocks = m == `MODE_UART9F ? (f ? 8'd32 : 8'd64) : 8'd128;
	endfunction
	task chk(input [63:0] name, input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("mismatch %0s exp %h seen %h", name, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge ref_clk);
			regAddr <= a;
			regWdata <= d;
			regWrite <= 1'b1;
			@(posedge ref_clk);
			regWrite <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge ref_clk);
			regAddr <= a;
			regRead <= 1'b1;
			@(posedge ref_clk);
			regRead <= 1'b0;
			#1 d = regRdata;
		end
	endtask
	task waitFlag(input tx);
		integer t;
		begin
			t = 0;
			while ((tx ? txDoneFlag : rxDoneFlag) !== 1'b1 && t < 4000) begin
				@(posedge ref_clk);
				t = t + 1;
			end
			chk("done", tx ? txDoneFlag : rxDoneFlag, 1'b1);
		end
	endtask
	task clear;
		begin
			wr(`ADDR_CTRL, 8'h00);
			repeat (2) @(posedge ref_clk);
			#1 chk("flags", {txDoneFlag, rxDoneFlag}, 2'b00);
		end
	endtask
	task results;
		begin
			if (n_fail == 0 && compares > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// ********************
	// Main sequence
	// ********************
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		{regWrite, regRead, baudTick, shift, nine} = 5'h00;
		{regAddr, regWdata, tickCnt} = 19'h00000;
		bitLen = 8'd128;
		{n_fail, compares, cycles} = 96'h0;
		seed = 28433;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(`ADDR_CTRL, v);
		chk("ctrl", v, `CTRL_RESET);
		rd(8'h00, v);
		chk("unmap", v, 8'h00);
		for (k = 0; k < 8; k = k + 1) begin
			c = cases[k];
			r = $random(seed);
			nine = c[7];
			bitLen = bitClocks(c[7:6], c[1]);
			wr(`ADDR_RATE, {7'h00, c[1]});
			wr(`ADDR_CTRL, {c[7:3], 3'b000});
			fork
				wr(`ADDR_BUF, r[7:0]);
				peer_u.sendAsync({c[3], r[15:8]}, c[2]);
			join
			waitFlag(1'b1);
			repeat (20) @(posedge ref_clk);
			chk("txf", cap, {2'b01, c[3], r[7:0]});
			chk("rxdone", rxDoneFlag, c[0]);
			if (c[0]) begin
				rd(`ADDR_BUF, v);
				chk("rxdata", v, r[15:8]);
				rd(`ADDR_CTRL, v);
				chk("rx9", v[`BIT_RX9], c[7] ? c[3] : c[2]);
			end
			clear;
		end
		nine = 1'b0;
		bitLen = 8'd128;
		wr(`ADDR_CTRL, 8'h50);
		r = $random(seed);
		peer_u.sendAsync({1'b1, r[7:0]}, 1'b1);
		fork
			peer_u.sendAsync({1'b1, r[15:8]}, 1'b1);
			begin
				repeat (600) @(posedge ref_clk);
				rd(`ADDR_BUF, v);
				chk("hold", v, r[7:0]);
			end
		join
		repeat (200) @(posedge ref_clk);
		rd(`ADDR_BUF, v);
		chk("ovr", v, r[7:0]);
		rd(`ADDR_STAT, v);
		chk("ovf", v[`BIT_ST_OVERRUN], 1'b1);
		wr(`ADDR_STAT, 8'h00);
		rd(`ADDR_STAT, v);
		chk("ovclr", v[`BIT_ST_OVERRUN], 1'b0);
		clear;
		shift = 1'b1;
		r = $random(seed);
		wr(`ADDR_BUF, r[7:0]);
		waitFlag(1'b1);
		chk("s0out", cap[7:0], r[7:0]);
		clear;
		peer_u.armShift(r[15:8]);
		wr(`ADDR_CTRL, 8'h30);
		waitFlag(1'b0);
		rd(`ADDR_BUF, v);
		chk("s0in", v, r[15:8]);
		clear;
		shift = 1'b0;
		results;
	end
endmodule // serial_port_four_mode_tb
